// ---- verilog/vcsw_pkg.sv ----
package vcsw_pkg;
   // Fault index positions in status and mask vectors
   localparam int FLT_RVG = 0;
   localparam int FLT_OCL = 1;
   localparam int FLT_OTP = 2;
   localparam int FLT_SHT = 3;
   localparam int FLT_W = 4;
   // Clock rate and timing
   localparam int CLK_MHZ = 125;
   localparam int SOFT_START_NS = 1000;
   localparam int SOFT_START_CYC = (SOFT_START_NS * CLK_MHZ + 999) / 1000;
   localparam int SHORT_OFF_NS = 2000;
   localparam int SHORT_OFF_CYC = (SHORT_OFF_NS * CLK_MHZ) / 1000;
   // Programmable field widths and soft-start level width
   localparam int DGL_W = 8;
   localparam int DLY_W = 16;
   localparam int CNT_W = 4;
   localparam int LVL_W = 2;
   localparam int SS_W = 8;
   // Delay prescaler: one tick per microsecond
   localparam int TICK_DIV = CLK_MHZ;
   localparam int TICK_W = 8;
   // Switch state machine
   typedef enum logic [2:0] {
      VCSW_OFF = 3'b000,
      VCSW_RAMP = 3'b001,
      VCSW_ON = 3'b010,
      VCSW_RVG_WAIT = 3'b011,
      VCSW_OTP_WAIT = 3'b100,
      VCSW_SHT_OFF = 3'b101,
      VCSW_LOCK = 3'b110
   } vcsw_state_e;
endpackage

// ---- verilog/vcsw_status.sv ----
`timescale 1ns/1ps
// Sticky fault status with mask and open-drain alert
module vcsw_status (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fault events and host access
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_set,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_clr,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_mask,
   // Results
   output logic [vcsw_pkg::FLT_W-1:0] fault_status,
   output logic [vcsw_pkg::FLT_W-1:0] irq_pending,
   output logic alert_n_o,
   output logic alert_n_oe
);
   logic [vcsw_pkg::FLT_W-1:0] status_ff;
   logic [vcsw_pkg::FLT_W-1:0] irq_ff;
   logic alert_ff;

   // Per-fault sticky bits; set beats clear
   genvar i;
   generate
      for (i = 0; i < vcsw_pkg::FLT_W; i++) begin : g_flt
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               status_ff[i] <= 1'b0;
               irq_ff[i] <= 1'b0;
            end else if (fault_set[i]) begin
               status_ff[i] <= 1'b1;
               irq_ff[i] <= 1'b1;
            end else if (fault_clr[i]) begin
               status_ff[i] <= 1'b0;
               irq_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Level alert while any unmasked interrupt pends
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alert_ff <= 1'b0;
      end else begin
         alert_ff <= |(irq_ff & ~fault_mask);
      end
   end

   assign fault_status = status_ff;
   assign irq_pending = irq_ff;
   assign alert_n_o = 1'b0;
   assign alert_n_oe = alert_ff;
endmodule // vcsw_status

// ---- verilog/vcsw_ctrl.sv ----
`timescale 1ns/1ps
module vcsw_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host control
   input wire logic host_enable,
   input wire logic comm_on_pin2,
   input wire logic reverse_voltage_guard_en,
   input wire logic [vcsw_pkg::LVL_W-1:0] current_limit_level,
   input wire logic [vcsw_pkg::DGL_W-1:0] deglitch_us,
   input wire logic [vcsw_pkg::CNT_W-1:0] reattempt_count,
   input wire logic [vcsw_pkg::DLY_W-1:0] rvg_reassert_us,
   input wire logic [vcsw_pkg::DLY_W-1:0] otp_reassert_us,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_mask,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_clear,
   // Analog comparator flags
   input wire logic cable_power_input_ok,
   input wire logic reverse_flag,
   input wire logic overcurrent_flag,
   input wire logic overtemp_flag,
   input wire logic temp_recovered_flag,
   input wire logic short_flag,
   // Switch drive
   output logic sw_cc1_en,
   output logic sw_cc2_en,
   output logic [vcsw_pkg::SS_W-1:0] soft_start_level,
   output logic current_limit_on,
   output logic [vcsw_pkg::LVL_W-1:0] current_limit_sel,
   // Status and alert
   output logic [vcsw_pkg::FLT_W-1:0] fault_status,
   output logic [vcsw_pkg::FLT_W-1:0] irq_pending,
   output logic [2:0] switch_state,
   output logic alert_n_o,
   output logic alert_n_oe
);
   // Two-flop synchronisers for the analog flags
   logic [5:0] raw_in;
   logic [5:0] meta_ff;
   logic [5:0] sync_ff;
   assign raw_in = {short_flag, temp_recovered_flag, overtemp_flag, overcurrent_flag, reverse_flag,
                    cable_power_input_ok};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= 6'h00;
         sync_ff <= 6'h00;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end
   logic pwr_ok, rev_s, oc_s, ot_s, cool_s, sht_s;
   assign {sht_s, cool_s, ot_s, oc_s, rev_s, pwr_ok} = sync_ff;

   vcsw_pkg::vcsw_state_e state_ff, nxt_state;
   logic [vcsw_pkg::TICK_W-1:0] tick_cnt_ff;
   logic tick;
   logic [vcsw_pkg::DGL_W-1:0] dgl_cnt_ff;
   logic [vcsw_pkg::DLY_W-1:0] dly_cnt_ff;
   logic [vcsw_pkg::CNT_W-1:0] tries_ff;
   logic [vcsw_pkg::SS_W-1:0] ramp_ff;
   logic [vcsw_pkg::SS_W-1:0] fast_cnt_ff;
   logic pin2_ff;
   logic rev_hit;
   logic active;
   logic [vcsw_pkg::FLT_W-1:0] fault_set;

   // One-microsecond tick enable
   always_ff @(posedge clk) begin
      if (!rst_n || tick) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 1'b1;
      end
   end
   assign tick = (tick_cnt_ff == vcsw_pkg::TICK_W'(vcsw_pkg::TICK_DIV - 1));

   // Switch allowed only with power present and host enable
   assign active = pwr_ok && host_enable;

   // Reverse voltage deglitch, counted in microseconds
   always_ff @(posedge clk) begin
      if (!rst_n || !rev_s || !reverse_voltage_guard_en || state_ff != vcsw_pkg::VCSW_ON) begin
         dgl_cnt_ff <= '0;
      end else if (tick && dgl_cnt_ff != deglitch_us) begin
         dgl_cnt_ff <= dgl_cnt_ff + 1'b1;
      end
   end
   assign rev_hit = rev_s && reverse_voltage_guard_en && state_ff == vcsw_pkg::VCSW_ON &&
                    dgl_cnt_ff == deglitch_us;

   // Next-state decision
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         vcsw_pkg::VCSW_OFF: begin
            if (active) nxt_state = vcsw_pkg::VCSW_RAMP;
         end
         vcsw_pkg::VCSW_RAMP: begin
            if (ramp_ff == vcsw_pkg::SS_W'(vcsw_pkg::SOFT_START_CYC)) nxt_state = vcsw_pkg::VCSW_ON;
            if (ot_s) nxt_state = vcsw_pkg::VCSW_OTP_WAIT;
            if (sht_s) nxt_state = vcsw_pkg::VCSW_SHT_OFF;
         end
         vcsw_pkg::VCSW_ON: begin
            if (rev_hit) begin
               if (tries_ff + 1'b1 >= reattempt_count) nxt_state = vcsw_pkg::VCSW_LOCK;
               else nxt_state = vcsw_pkg::VCSW_RVG_WAIT;
            end
            if (ot_s) nxt_state = vcsw_pkg::VCSW_OTP_WAIT;
            if (sht_s) nxt_state = vcsw_pkg::VCSW_SHT_OFF;
         end
         vcsw_pkg::VCSW_RVG_WAIT: begin
            if (dly_cnt_ff == rvg_reassert_us) nxt_state = vcsw_pkg::VCSW_RAMP;
         end
         vcsw_pkg::VCSW_OTP_WAIT: begin
            if (cool_s && !ot_s && dly_cnt_ff == otp_reassert_us) nxt_state = vcsw_pkg::VCSW_RAMP;
         end
         vcsw_pkg::VCSW_SHT_OFF: begin
            if (fast_cnt_ff == vcsw_pkg::SS_W'(vcsw_pkg::SHORT_OFF_CYC)) nxt_state = vcsw_pkg::VCSW_RAMP;
         end
         vcsw_pkg::VCSW_LOCK: begin
            nxt_state = vcsw_pkg::VCSW_LOCK;
         end
         default: nxt_state = vcsw_pkg::VCSW_OFF;
      endcase
      if (!active) nxt_state = vcsw_pkg::VCSW_OFF;
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= vcsw_pkg::VCSW_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Orientation latched on each turn-on from off
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin2_ff <= 1'b0;
      end else if (state_ff == vcsw_pkg::VCSW_OFF) begin
         pin2_ff <= comm_on_pin2;
      end
   end

   // Soft-start ramp counter
   always_ff @(posedge clk) begin
      if (!rst_n || state_ff != vcsw_pkg::VCSW_RAMP) begin
         ramp_ff <= '0;
      end else if (ramp_ff != vcsw_pkg::SS_W'(vcsw_pkg::SOFT_START_CYC)) begin
         ramp_ff <= ramp_ff + 1'b1;
      end
   end

   // Short-circuit off time counter
   always_ff @(posedge clk) begin
      if (!rst_n || state_ff != vcsw_pkg::VCSW_SHT_OFF) begin
         fast_cnt_ff <= '0;
      end else begin
         fast_cnt_ff <= fast_cnt_ff + 1'b1;
      end
   end

   // Reassert delay counter in microseconds
   always_ff @(posedge clk) begin
      if (!rst_n || (state_ff != vcsw_pkg::VCSW_RVG_WAIT && state_ff != vcsw_pkg::VCSW_OTP_WAIT) ||
          state_ff != nxt_state) begin
         dly_cnt_ff <= '0;
      end else if (tick && dly_cnt_ff != {vcsw_pkg::DLY_W{1'b1}}) begin
         dly_cnt_ff <= dly_cnt_ff + 1'b1;
      end
   end

   // Reattempt counter
   always_ff @(posedge clk) begin
      if (!rst_n || state_ff == vcsw_pkg::VCSW_OFF) begin
         tries_ff <= '0;
      end else if (state_ff == vcsw_pkg::VCSW_ON && rev_hit) begin
         tries_ff <= tries_ff + 1'b1;
      end else if (state_ff == vcsw_pkg::VCSW_ON && !rev_s && dgl_cnt_ff == '0 && ramp_ff == '0) begin
         tries_ff <= tries_ff; // Holds while on; cleared only in VCSW_OFF, by the reset branch above
      end
   end

   // Fault events
   always_comb begin
      fault_set = '0;
      fault_set[vcsw_pkg::FLT_RVG] = state_ff == vcsw_pkg::VCSW_ON && nxt_state == vcsw_pkg::VCSW_LOCK;
      fault_set[vcsw_pkg::FLT_OCL] = oc_s && (state_ff == vcsw_pkg::VCSW_ON || state_ff == vcsw_pkg::VCSW_RAMP);
      fault_set[vcsw_pkg::FLT_OTP] = ot_s && (state_ff == vcsw_pkg::VCSW_ON || state_ff == vcsw_pkg::VCSW_RAMP);
      fault_set[vcsw_pkg::FLT_SHT] = sht_s && (state_ff == vcsw_pkg::VCSW_ON || state_ff == vcsw_pkg::VCSW_RAMP);
   end

   vcsw_status u_status (
      .clk(clk),
      .rst_n(rst_n),
      .fault_set(fault_set),
      .fault_clr(fault_clear),
      .fault_mask(fault_mask),
      .fault_status(fault_status),
      .irq_pending(irq_pending),
      .alert_n_o(alert_n_o),
      .alert_n_oe(alert_n_oe)
   );

   // Switch drive registers
   logic closed;
   assign closed = nxt_state == vcsw_pkg::VCSW_RAMP || nxt_state == vcsw_pkg::VCSW_ON;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_cc1_en <= 1'b0;
         sw_cc2_en <= 1'b0;
         soft_start_level <= '0;
         current_limit_on <= 1'b0;
         current_limit_sel <= '0;
      end else begin
         sw_cc1_en <= closed && pin2_ff;
         sw_cc2_en <= closed && !pin2_ff;
         soft_start_level <= (nxt_state == vcsw_pkg::VCSW_ON) ? {vcsw_pkg::SS_W{1'b1}} :
                             (nxt_state == vcsw_pkg::VCSW_RAMP) ? ramp_ff : '0;
         current_limit_on <= closed && oc_s;
         current_limit_sel <= current_limit_level;
      end
   end

   assign switch_state = state_ff;
endmodule // vcsw_ctrl

// ---- dv/vcsw_ctrl_sva.sv ----
`timescale 1ns/1ps
// Port-level checks of the switch controller
module vcsw_ctrl_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host and supply
   input wire logic host_enable,
   input wire logic cable_power_input_ok,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_clear,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_mask,
   // Switch and status
   input wire logic sw_cc1_en,
   input wire logic sw_cc2_en,
   input wire logic [vcsw_pkg::SS_W-1:0] soft_start_level,
   input wire logic current_limit_on,
   input wire logic [vcsw_pkg::FLT_W-1:0] fault_status,
   input wire logic [vcsw_pkg::FLT_W-1:0] irq_pending,
   input wire logic [2:0] switch_state,
   input wire logic alert_n_o,
   input wire logic alert_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Switch path
   chk_one_pin: assert property (!(sw_cc1_en && sw_cc2_en)) else $error("both pins powered");
   chk_hiz_off: assert property (switch_state == 3'd0 |-> !sw_cc1_en && !sw_cc2_en)
      else $error("pin driven while off");
   chk_ramp_first: assert property ($rose(sw_cc1_en | sw_cc2_en) |-> switch_state == 3'd1
      && soft_start_level != 8'hff) else $error("switch closed without ramp");
   chk_no_power: assert property (!cable_power_input_ok [*4] |-> switch_state == 3'd0)
      else $error("switch active without supply");
   chk_host_off: assert property (!host_enable [*2] |-> switch_state == 3'd0)
      else $error("host off ignored");
   chk_limit_closed: assert property (current_limit_on |-> sw_cc1_en || sw_cc2_en)
      else $error("limiting while open");
   chk_lock_status: assert property (switch_state == 3'd6 |-> fault_status[0])
      else $error("lock without reverse status");
   // Status and alert
   chk_irq_subset: assert property ((irq_pending & ~fault_status) == 4'h0)
      else $error("irq without status");
   chk_sticky: assert property (($past(fault_status) & ~fault_status & ~$past(fault_clear)) == 4'h0)
      else $error("status dropped without clear");
   chk_alert_lvl: assert property (alert_n_oe == (|($past(irq_pending) & ~$past(fault_mask))))
      else $error("alert does not follow pending");
   chk_alert_low: assert property (alert_n_oe |-> !alert_n_o) else $error("alert not pulled low");
endmodule // vcsw_ctrl_sva
bind vcsw_ctrl vcsw_ctrl_sva i_vcsw_ctrl_sva (.clk, .rst_n, .host_enable, .cable_power_input_ok,
   .fault_clear, .fault_mask, .sw_cc1_en, .sw_cc2_en, .soft_start_level, .current_limit_on, .fault_status,
   .irq_pending, .switch_state, .alert_n_o, .alert_n_oe);

// ---- dv/vcsw_cable_model.sv ----
`timescale 1ns/1ps
// Powered cable: fault comparators only see current while the switch conducts
module vcsw_cable_model (
   // Switch drive
   input wire logic sw_cc1_en,
   input wire logic sw_cc2_en,
   // Fault kind: 0 good, 1 reverse, 2 overload, 3 short
   input wire logic [1:0] mode,
   // Comparator flags
   output logic reverse_flag,
   output logic overcurrent_flag,
   output logic short_flag
);
   logic closed;
   // Flags fall back to idle low when the path is open
   assign closed = sw_cc1_en | sw_cc2_en;
   assign reverse_flag = closed && mode == 2'd1;
   assign overcurrent_flag = closed && mode == 2'd2;
   assign short_flag = closed && mode == 2'd3;
endmodule // vcsw_cable_model

// ---- dv/vcsw_ctrl_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
// Self-checking bench of the switch controller
module vcsw_ctrl_tb;
   logic clk, rst_n, host_enable, comm_on_pin2, reverse_voltage_guard_en, cable_power_input_ok;
   logic reverse_flag, overcurrent_flag, overtemp_flag, temp_recovered_flag, short_flag;
   logic sw_cc1_en, sw_cc2_en, current_limit_on, alert_n_o, alert_n_oe;
   logic [1:0] current_limit_level, current_limit_sel, cable_mode;
   logic [7:0] deglitch_us, soft_start_level;
   logic [3:0] reattempt_count, fault_mask, fault_clear, fault_status, irq_pending;
   logic [15:0] rvg_reassert_us, otp_reassert_us;
   logic [2:0] switch_state;
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 27;
   // Device and far side
   vcsw_ctrl i_vcsw_ctrl (.clk, .rst_n, .host_enable, .comm_on_pin2, .reverse_voltage_guard_en,
      .current_limit_level, .deglitch_us, .reattempt_count, .rvg_reassert_us, .otp_reassert_us,
      .fault_mask, .fault_clear, .cable_power_input_ok, .reverse_flag, .overcurrent_flag,
      .overtemp_flag, .temp_recovered_flag, .short_flag, .sw_cc1_en, .sw_cc2_en, .soft_start_level,
      .current_limit_on, .current_limit_sel, .fault_status, .irq_pending, .switch_state,
      .alert_n_o, .alert_n_oe);
   vcsw_cable_model i_vcsw_cable_model (.sw_cc1_en, .sw_cc2_en, .mode(cable_mode), .reverse_flag,
      .overcurrent_flag, .short_flag);
   // 125 MHz clock
   always #4 clk = ~clk;
   // Verdict
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Wait on the state code within a bound, then compare
   task automatic wt(input logic [2:0] s, input int mx);
      int i;
      i = 0;
      while (switch_state !== s && i < mx) begin
         @(negedge clk);
         i++;
      end
      `CHK("state", s, switch_state)
   endtask
   task automatic tdone(input string t);
      $display("test %s done", t);
   endtask
   // Watchdog
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      host_enable = 1'b0;
      comm_on_pin2 = 1'b0;
      reverse_voltage_guard_en = 1'b0;
      current_limit_level = 2'h0;
      deglitch_us = 8'h02;
      reattempt_count = 4'h2;
      rvg_reassert_us = 16'h0002;
      otp_reassert_us = 16'h0002;
      fault_mask = 4'h0;
      fault_clear = 4'h0;
      cable_power_input_ok = 1'b0;
      overtemp_flag = 1'b0;
      temp_recovered_flag = 1'b0;
      cable_mode = 2'h0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      `CHK("alert", 1'b0, alert_n_oe)
      wt(3'd0, 0);
      // Power-up on a random orientation
      comm_on_pin2 = 1'($random(seed));
      cable_power_input_ok = 1'b1;
      host_enable = 1'b1;
      wt(3'd1, 8);
      `CHK("cc1", comm_on_pin2, sw_cc1_en)
      `CHK("cc2", ~comm_on_pin2, sw_cc2_en)
      wt(3'd2, 200);
      `CHK("ramp", 8'hff, soft_start_level)
      tdone("powerup");
      // Supply loss and return
      cable_power_input_ok = 1'b0;
      wt(3'd0, 8);
      `CHK("hiz", 2'b00, {sw_cc1_en, sw_cc2_en})
      cable_power_input_ok = 1'b1;
      wt(3'd2, 200);
      tdone("supply");
      // Overload with four random limit levels
      cable_mode = 2'h2;
      for (int k = 0; k < 4; k++) begin
         current_limit_level = 2'(k + $random(seed));
         repeat (4) @(negedge clk);
         `CHK("sel", current_limit_level, current_limit_sel)
      end
      `CHK("limit", 1'b1, current_limit_on)
      wt(3'd2, 0);
      `CHK("oc status", 1'b1, fault_status[1])
      cable_mode = 2'h1;
      tdone("overload");
      // Reverse voltage ignored, then trips to lock
      repeat (600) @(negedge clk);
      wt(3'd2, 0);
      reverse_voltage_guard_en = 1'b1;
      wt(3'd3, 500);
      `CHK("rvg open", 2'b00, {sw_cc1_en, sw_cc2_en})
      wt(3'd1, 500);
      wt(3'd6, 1000);
      repeat (3) @(negedge clk);
      `CHK("rvg status", 1'b1, fault_status[0])
      `CHK("alert", 1'b1, alert_n_oe)
      tdone("reverse");
      // Host off overrides, status cleared
      host_enable = 1'b0;
      cable_mode = 2'h0;
      wt(3'd0, 4);
      fault_clear = 4'hf;
      @(negedge clk);
      fault_clear = 4'h0;
      repeat (2) @(negedge clk);
      `CHK("cleared", 4'h0, fault_status)
      `CHK("alert", 1'b0, alert_n_oe)
      tdone("hostoff");
      // Over-temperature shutdown and recovery
      host_enable = 1'b1;
      wt(3'd2, 200);
      overtemp_flag = 1'b1;
      wt(3'd4, 8);
      `CHK("otp status", 1'b1, fault_status[2])
      overtemp_flag = 1'b0;
      temp_recovered_flag = 1'b1;
      wt(3'd1, 600);
      temp_recovered_flag = 1'b0;
      wt(3'd2, 200);
      tdone("thermal");
      // Short with its alert masked
      fault_mask = 4'h8;
      fault_clear = 4'hf;
      @(negedge clk);
      fault_clear = 4'h0;
      cable_mode = 2'h3;
      wt(3'd5, 8);
      cable_mode = 2'h0;
      `CHK("short status", 1'b1, fault_status[3])
      wt(3'd1, 300);
      `CHK("short level", current_limit_level, current_limit_sel)
      `CHK("masked", 1'b0, alert_n_oe)
      `CHK("short irq", 1'b1, irq_pending[3])
      `CHK("alert level", 1'b0, alert_n_o)
      tdone("short");
      end_sim;
   end
endmodule // vcsw_ctrl_tb
